// ===== hdl/ebcs_rdy_cond.sv
/*
 * Handshake input conditioner: direct sample or two-stage synchroniser,
 * then polarity. Assumes the bus clock and the shared reset.
 */
`timescale 1ns/1ns
module ebcs_rdy_cond (
    input wire logic clk_in,
    input wire logic rst_n_in,
    ebcs_rdy_if.cond rif
);
    logic direct_q;
    logic meta_q;
    logic sync_q;
    logic ok_q;

    // Direct sample for a module timed to the reference clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            direct_q <= 1'b0;
        end else begin
            direct_q <= rif.ready_pin;
        end
    end

    // Extra stage costs one wait state but tolerates any timing
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= rif.ready_pin;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ok_q <= 1'b0;
        end else begin
            ok_q <= (rif.async_mode ? sync_q : direct_q) ~^ rif.active_high;
        end
    end

    assign rif.ready_ok = ok_q;
endmodule : ebcs_rdy_cond

// ===== hdl/ebcs_top.sv
/*
 * External bus cycle sequencer: register port on mclk_in, bus cycles on
 * the bus clock. Assumes synchronous read data and a master that never
 * strobes read and write together.
 */
`timescale 1ns/1ns
`include "ebcs_regs.svh"

module ebcs_top #(
    parameter int NCS = 2
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic bus_clk_in,
    output logic reference_clock_output_out,
    output logic refclk_drv_en_out,
    output logic [23:0] addr_out,
    output logic [15:0] ad_out,
    output logic ad_oe_out,
    input wire logic [15:0] ad_in,
    output logic ale_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic high_byte_enable_n_out,
    output logic [NCS-1:0] cs_n_out,
    input wire logic ready_in
);
    localparam int CSW = (NCS > 1) ? $clog2(NCS) : 1;

    // Register side state
    logic [`EBCS_CTRL_W-1:0] ctrl_q;
    logic [`EBCS_TIM_W-1:0] tim_q [NCS];
    logic [23:0] m_addr_q;
    logic [15:0] m_wdata_q;
    logic [15:0] m_rdata_q;
    logic [CSW-1:0] m_cs_q;
    logic m_write_q;
    logic m_byte_q;
    logic [`EBCS_CTRL_W-1:0] m_ctrl_q;
    ebcs_pkg::ebcs_timing_s m_tim_q;
    logic busy_q;
    logic done_q;
    logic req_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic ack_evt;
    logic start;
    logic [CSW-1:0] start_cs;

    // Bus side state
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic pend_q;
    logic ack_tgl_q;
    logic [23:0] b_addr_q;
    logic [15:0] b_wdata_q;
    logic [15:0] b_rdata_q;
    logic [CSW-1:0] b_cs_q;
    logic b_write_q;
    logic b_byte_q;
    logic b_mux_q;
    logic b_rdy_en_q;
    logic b_ext_q;
    ebcs_pkg::ebcs_timing_s b_tim_q;
    logic [7:0] last_win_q;
    logic [CSW-1:0] last_cs_q;
    logic used_q;
    ebcs_pkg::ebcs_phase_e st_q;
    ebcs_pkg::ebcs_phase_e st_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic refen_s1_q;
    logic refen_s2_q;
    logic refen_n_q;
    logic rdy_hi_q;
    logic rdy_async_q;
    logic [15:0] ad_q;
    logic ad_oe_q;
    logic ale_q;
    logic rd_n_q;
    logic wr_n_q;
    logic bhe_n_q;
    logic [NCS-1:0] cs_n_q;
    logic [23:0] addr_q;

    ebcs_rdy_if rif ();

    // Register port
    assign start_cs = reg_wdata_in[`EBCS_CMD_CS_LSB +: CSW];
    assign start = reg_wr_in && (reg_addr_in == `EBCS_OFS_CMD)
        && reg_wdata_in[`EBCS_CMD_START] && !busy_q && (32'(start_cs) < NCS);
    assign ack_evt = ack_s2_q ^ ack_s3_q;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= `EBCS_CTRL_RST;
        end else if (reg_wr_in && reg_addr_in == `EBCS_OFS_CTRL) begin
            ctrl_q <= reg_wdata_in[`EBCS_CTRL_W-1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NCS; i++) begin
                tim_q[i] <= `EBCS_TIM_RST;
            end
        end else if (reg_wr_in) begin
            for (int i = 0; i < NCS; i++) begin
                if (reg_addr_in == `EBCS_OFS_TIM0 + 8'(i) * `EBCS_TIM_STRIDE) begin
                    tim_q[i] <= reg_wdata_in[`EBCS_TIM_W-1:0];
                end
            end
        end
    end

    // Address and data stay frozen while a cycle runs
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            m_addr_q <= 24'h000000;
            m_wdata_q <= 16'h0000;
        end else if (!busy_q && reg_wr_in) begin
            if (reg_addr_in == `EBCS_OFS_ADDR) begin
                m_addr_q <= reg_wdata_in[23:0];
            end
            if (reg_addr_in == `EBCS_OFS_WDATA) begin
                m_wdata_q <= reg_wdata_in[15:0];
            end
        end
    end

    // Command snapshot, handed over by toggle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            m_cs_q <= '0;
            m_write_q <= 1'b0;
            m_byte_q <= 1'b0;
            m_ctrl_q <= `EBCS_CTRL_RST;
            m_tim_q <= '0;
            req_tgl_q <= 1'b0;
        end else if (start) begin
            m_cs_q <= start_cs;
            m_write_q <= reg_wdata_in[`EBCS_CMD_WRITE];
            m_byte_q <= reg_wdata_in[`EBCS_CMD_BYTE];
            m_ctrl_q <= ctrl_q;
            m_tim_q <= ebcs_pkg::ebcs_decode(tim_q[start_cs]);
            req_tgl_q <= !req_tgl_q;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // Completion beats a new start; start only when idle anyway
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            m_rdata_q <= 16'h0000;
        end else if (ack_evt) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            m_rdata_q <= b_rdata_q;
        end else if (start) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `EBCS_OFS_CTRL: reg_rdata_out <= 32'(ctrl_q);
                `EBCS_OFS_ADDR: reg_rdata_out <= 32'(m_addr_q);
                `EBCS_OFS_WDATA: reg_rdata_out <= 32'(m_wdata_q);
                `EBCS_OFS_STATUS: reg_rdata_out <= 32'({done_q, busy_q});
                `EBCS_OFS_RDATA: reg_rdata_out <= 32'(m_rdata_q);
                default: begin
                    reg_rdata_out <= 32'h00000000;
                    for (int i = 0; i < NCS; i++) begin
                        if (reg_addr_in == `EBCS_OFS_TIM0 + 8'(i) * `EBCS_TIM_STRIDE) begin
                            reg_rdata_out <= 32'(tim_q[i]);
                        end
                    end
                end
            endcase
        end else begin
            reg_rdata_out <= 32'h00000000;
        end
    end

    // Bus side: request crossing
    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // Phase length in clock units, zero means skipped
    function automatic logic [5:0] phase_len(input ebcs_pkg::ebcs_phase_e p);
        logic [5:0] n;
        n = 6'h00;
        unique case (p)
            ebcs_pkg::EBCS_AB: n = (b_tim_q.ab_two ? 6'h02 : 6'h01)
                + (b_ext_q ? 6'(b_tim_q.ab_ext) : 6'h00);
            ebcs_pkg::EBCS_C: n = 6'(b_tim_q.cmd_delay);
            ebcs_pkg::EBCS_D: n = 6'(b_tim_q.wr_setup);
            ebcs_pkg::EBCS_E: n = 6'(b_tim_q.access_m1) + 6'h01;
            ebcs_pkg::EBCS_F: n = 6'(b_tim_q.hold);
            ebcs_pkg::EBCS_IDLE, ebcs_pkg::EBCS_RDY: n = 6'h00;
        endcase
        return n;
    endfunction : phase_len

    // First non-empty phase after the given one, fixed order
    function automatic ebcs_pkg::ebcs_phase_e next_phase(input ebcs_pkg::ebcs_phase_e p);
        ebcs_pkg::ebcs_phase_e n;
        n = ebcs_pkg::EBCS_IDLE;
        unique case (p)
            ebcs_pkg::EBCS_IDLE: n = ebcs_pkg::EBCS_AB;
            ebcs_pkg::EBCS_AB: n = (phase_len(ebcs_pkg::EBCS_C) != 6'h00) ? ebcs_pkg::EBCS_C
                : (phase_len(ebcs_pkg::EBCS_D) != 6'h00) ? ebcs_pkg::EBCS_D
                : ebcs_pkg::EBCS_E;
            ebcs_pkg::EBCS_C: n = (phase_len(ebcs_pkg::EBCS_D) != 6'h00) ? ebcs_pkg::EBCS_D
                : ebcs_pkg::EBCS_E;
            ebcs_pkg::EBCS_D: n = ebcs_pkg::EBCS_E;
            ebcs_pkg::EBCS_E, ebcs_pkg::EBCS_RDY: n =
                (phase_len(ebcs_pkg::EBCS_F) != 6'h00) ? ebcs_pkg::EBCS_F : ebcs_pkg::EBCS_IDLE;
            ebcs_pkg::EBCS_F: n = ebcs_pkg::EBCS_IDLE;
        endcase
        return n;
    endfunction : next_phase

    // Window change check is done at load, before the setup phase
    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'b0;
            b_addr_q <= 24'h000000;
            b_wdata_q <= 16'h0000;
            b_cs_q <= '0;
            b_write_q <= 1'b0;
            b_byte_q <= 1'b0;
            b_mux_q <= 1'b0;
            b_rdy_en_q <= 1'b0;
            b_ext_q <= 1'b0;
            b_tim_q <= '0;
            rdy_hi_q <= 1'b0;
            rdy_async_q <= 1'b0;
        end else if (req_s2_q ^ req_s3_q) begin
            pend_q <= 1'b1;
            b_addr_q <= m_addr_q;
            b_wdata_q <= m_wdata_q;
            b_cs_q <= m_cs_q;
            b_write_q <= m_write_q;
            b_byte_q <= m_byte_q;
            b_mux_q <= m_ctrl_q[`EBCS_CTRL_MUX];
            b_rdy_en_q <= m_ctrl_q[`EBCS_CTRL_RDY_EN];
            rdy_hi_q <= m_ctrl_q[`EBCS_CTRL_RDY_HI];
            rdy_async_q <= m_ctrl_q[`EBCS_CTRL_RDY_ASYNC];
            b_tim_q <= m_tim_q;
            b_ext_q <= !used_q || last_cs_q != m_cs_q
                || last_win_q != m_addr_q[`EBCS_WIN_LSB +: 8];
        end else if (st_q == ebcs_pkg::EBCS_IDLE) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            used_q <= 1'b0;
            last_cs_q <= '0;
            last_win_q <= 8'h00;
        end else if (st_q == ebcs_pkg::EBCS_AB) begin
            used_q <= 1'b1;
            last_cs_q <= b_cs_q;
            last_win_q <= b_addr_q[`EBCS_WIN_LSB +: 8];
        end
    end

    assign rif.ready_pin = ready_in;
    assign rif.active_high = rdy_hi_q;
    assign rif.async_mode = rdy_async_q;

    ebcs_rdy_cond u_rdy (
        .clk_in(bus_clk_in),
        .rst_n_in(rst_n_in),
        .rif(rif)
    );

    // Phase sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            ebcs_pkg::EBCS_IDLE: begin
                if (pend_q) begin
                    st_d = ebcs_pkg::EBCS_AB;
                    cnt_d = 5'(phase_len(ebcs_pkg::EBCS_AB) - 6'h01);
                end
            end
            ebcs_pkg::EBCS_E, ebcs_pkg::EBCS_RDY: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - 5'h01;
                end else if (b_rdy_en_q && !rif.ready_ok) begin
                    st_d = ebcs_pkg::EBCS_RDY;
                end else begin
                    st_d = next_phase(st_q);
                    cnt_d = 5'(phase_len(st_d) - 6'h01);
                end
            end
            default: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - 5'h01;
                end else begin
                    st_d = next_phase(st_q);
                    cnt_d = 5'(phase_len(st_d) - 6'h01);
                end
            end
        endcase
    end

    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= ebcs_pkg::EBCS_IDLE;
            cnt_q <= 5'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Read data taken on the edge that ends the strobe
    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            b_rdata_q <= 16'h0000;
        end else if (!b_write_q && !rd_n_q && rd_n_d()) begin
            b_rdata_q <= ad_in;
        end
    end

    function automatic logic rd_n_d();
        return !(!b_write_q && (st_d == ebcs_pkg::EBCS_E || st_d == ebcs_pkg::EBCS_RDY));
    endfunction : rd_n_d

    // Completion toggle; the read data above is loaded on or before the edge it flips on
    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_tgl_q <= 1'b0;
        end else if (st_q != ebcs_pkg::EBCS_IDLE && st_d == ebcs_pkg::EBCS_IDLE) begin
            ack_tgl_q <= !ack_tgl_q;
        end
    end

    // Pins, registered from the next phase
    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_n_q <= '1;
            ale_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            bhe_n_q <= 1'b1;
            addr_q <= 24'h000000;
        end else begin
            for (int i = 0; i < NCS; i++) begin
                cs_n_q[i] <= !(st_d != ebcs_pkg::EBCS_IDLE && 32'(b_cs_q) == i);
            end
            ale_q <= b_mux_q && st_d == ebcs_pkg::EBCS_AB;
            rd_n_q <= rd_n_d();
            wr_n_q <= !(b_write_q
                && (st_d == ebcs_pkg::EBCS_E || st_d == ebcs_pkg::EBCS_RDY));
            bhe_n_q <= !(st_d != ebcs_pkg::EBCS_IDLE && !b_byte_q);
            if (st_d == ebcs_pkg::EBCS_AB) begin
                addr_q <= b_addr_q;
            end
        end
    end

    // Shared lines: address early in shared mode, write data from setup on
    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ad_q <= 16'h0000;
            ad_oe_q <= 1'b0;
        end else begin
            unique case (st_d)
                ebcs_pkg::EBCS_AB, ebcs_pkg::EBCS_C: begin
                    ad_q <= b_addr_q[15:0];
                    ad_oe_q <= b_mux_q;
                end
                ebcs_pkg::EBCS_D, ebcs_pkg::EBCS_E, ebcs_pkg::EBCS_RDY, ebcs_pkg::EBCS_F: begin
                    ad_q <= b_wdata_q;
                    ad_oe_q <= b_write_q;
                end
                ebcs_pkg::EBCS_IDLE: begin
                    ad_q <= ad_q;
                    ad_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Reference clock: gate changes only while the clock is low
    always_ff @(posedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            refen_s1_q <= 1'b0;
            refen_s2_q <= 1'b0;
        end else begin
            refen_s1_q <= ctrl_q[`EBCS_CTRL_REFCLK_EN];
            refen_s2_q <= refen_s1_q;
        end
    end

    always_ff @(negedge bus_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            refen_n_q <= 1'b0;
        end else begin
            refen_n_q <= refen_s2_q;
        end
    end

    assign reference_clock_output_out = bus_clk_in & refen_n_q;
    assign refclk_drv_en_out = refen_n_q;
    assign addr_out = addr_q;
    assign ad_out = ad_q;
    assign ad_oe_out = ad_oe_q;
    assign ale_out = ale_q;
    assign rd_n_out = rd_n_q;
    assign wr_n_out = wr_n_q;
    assign high_byte_enable_n_out = bhe_n_q;
    assign cs_n_out = cs_n_q;

endmodule : ebcs_top

// ===== shared/ebcs_pkg.sv
/*
 * Types of the sequencer: bus phases and decoded chip select timing.
 * Assumes the constants header is compiled alongside.
 */
package ebcs_pkg;

    typedef enum logic [2:0] {
        EBCS_IDLE, EBCS_AB, EBCS_C, EBCS_D, EBCS_E, EBCS_RDY, EBCS_F
    } ebcs_phase_e;

    // One chip select timing configuration, decoded
    typedef struct packed {
        logic ab_two;
        logic [1:0] ab_ext;
        logic [1:0] cmd_delay;
        logic wr_setup;
        logic [4:0] access_m1;
        logic [1:0] hold;
    } ebcs_timing_s;

    function automatic ebcs_timing_s ebcs_decode(input logic [12:0] w);
        ebcs_timing_s t;
        t.ab_two = w[0];
        t.ab_ext = w[2:1];
        t.cmd_delay = w[4:3];
        t.wr_setup = w[5];
        t.access_m1 = w[10:6];
        t.hold = w[12:11];
        return t;
    endfunction : ebcs_decode

endpackage : ebcs_pkg

// ===== shared/ebcs_rdy_if.sv
/*
 * Carrier between the sequencer and its handshake conditioner.
 * Assumes both ends sit in the bus clock domain.
 */
`timescale 1ns/1ns
interface ebcs_rdy_if;
    logic ready_pin;
    logic active_high;
    logic async_mode;
    logic ready_ok;

    modport seq (output ready_pin, output active_high, output async_mode, input ready_ok);
    modport cond (input ready_pin, input active_high, input async_mode, output ready_ok);
endinterface : ebcs_rdy_if

// ===== shared/ebcs_regs.svh
/*
 * Register offsets, field positions and reset values of the external bus
 * cycle sequencer. Assumes inclusion by bare name from shared/.
 */
`ifndef EBCS_REGS_SVH
`define EBCS_REGS_SVH

// Register byte offsets, 8-bit address
`define EBCS_OFS_CTRL 8'h00
`define EBCS_OFS_TIM0 8'h04
`define EBCS_OFS_TIM1 8'h08
`define EBCS_OFS_ADDR 8'h0c
`define EBCS_OFS_WDATA 8'h10
`define EBCS_OFS_CMD 8'h14
`define EBCS_OFS_STATUS 8'h18
`define EBCS_OFS_RDATA 8'h1c
`define EBCS_TIM_STRIDE 8'h04

// Control fields
`define EBCS_CTRL_MUX 0
`define EBCS_CTRL_RDY_EN 1
`define EBCS_CTRL_RDY_HI 2
`define EBCS_CTRL_RDY_ASYNC 3
`define EBCS_CTRL_REFCLK_EN 4
`define EBCS_CTRL_W 5
`define EBCS_CTRL_RST 5'h11

// Command fields
`define EBCS_CMD_START 0
`define EBCS_CMD_WRITE 1
`define EBCS_CMD_BYTE 2
`define EBCS_CMD_CS_LSB 4

// Status fields
`define EBCS_STAT_BUSY 0
`define EBCS_STAT_DONE 1

// Chip select timing word layout
`define EBCS_TIM_AB_TWO 0
`define EBCS_TIM_AB_EXT_LSB 1
`define EBCS_TIM_C_LSB 3
`define EBCS_TIM_D 5
`define EBCS_TIM_E_LSB 6
`define EBCS_TIM_F_LSB 11
`define EBCS_TIM_W 13
`define EBCS_TIM_RST 13'h0000

// Address bits that form the address window
`define EBCS_WIN_LSB 16

`endif

// ===== test/ebcs_mem_model.sv
/* Memory on the far side of the bus, with a handshake raised after a set
   number of command clocks. Assumes the pins of ebcs_top. */
`timescale 1ns/1ns
module ebcs_mem_model (
    input wire logic bus_clk_in,
    input wire logic [23:0] addr_out,
    input wire logic [15:0] ad_out,
    input wire logic ad_oe_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic [5:0] wait_in,
    input wire logic act_hi_in,
    output logic [15:0] ad_in,
    output logic ready_in
);
    logic [15:0] mem [16];
    logic [15:0] idle_q = 16'h5a5a;
    logic [5:0] n_q = 6'h00;
    logic rdy_q = 1'b0;
    always @(posedge bus_clk_in) begin
        if (!wr_n_out)
            mem[addr_out[3:0]] <= ad_out;
        idle_q <= ~idle_q;
        n_q <= (rd_n_out && wr_n_out) ? 6'h00 : n_q + 6'h01;
        // Held until the strobe rises, dropped long before the next cycle
        rdy_q <= !(rd_n_out && wr_n_out) && n_q >= wait_in;
    end
    // Released lines toggle so a late sample never matches by luck
    assign ad_in = ad_oe_out ? ad_out : (!rd_n_out ? mem[addr_out[3:0]] : idle_q);
    assign ready_in = rdy_q ~^ act_hi_in;
endmodule : ebcs_mem_model

// ===== test/ebcs_monitor.sv
/* Pin checker for the bus cycle sequencer.
   Assumes it is bound into ebcs_top and sees only its pins. */
`timescale 1ns/1ns
module ebcs_monitor #(
    parameter int NCS = 2
) (
    input wire logic bus_clk_in,
    input wire logic rst_n_in,
    input wire logic reference_clock_output_out,
    input wire logic refclk_drv_en_out,
    input wire logic [23:0] addr_out,
    input wire logic ad_oe_out,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic [NCS-1:0] cs_n_out
);
    default clocking @(posedge bus_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic cmd = !rd_n_out || !wr_n_out;
    a_cmd_in_select: assert property (cmd |-> !(&cs_n_out))
        else $error("command outside chip select");
    a_no_dual_cmd: assert property (!(!rd_n_out && !wr_n_out))
        else $error("read and write strobes together");
    a_ale_drives_ad: assert property (ale_out |-> ad_oe_out && !cmd)
        else $error("latch strobe without address drive");
    a_read_released: assert property (!rd_n_out |-> !ad_oe_out)
        else $error("lines driven during read");
    a_write_driven: assert property (!wr_n_out |-> ad_oe_out)
        else $error("write data not driven");
    a_addr_held: assert property (!(&cs_n_out) && !(&$past(cs_n_out)) |-> $stable(addr_out))
        else $error("address moved inside cycle");
    a_hold_bounded: assert property ($rose(rd_n_out) || $rose(wr_n_out)
        |-> ##[0:3] &cs_n_out)
        else $error("hold phase too long");
    a_setup_first: assert property ($fell(rd_n_out) |-> !(&$past(cs_n_out)) && !ale_out)
        else $error("command without address setup");
    a_refclk_gated: assert property (@(negedge bus_clk_in)
        reference_clock_output_out == refclk_drv_en_out)
        else $error("reference clock not following enable");
endmodule : ebcs_monitor

bind ebcs_top ebcs_monitor #(.NCS(NCS)) i_mon (.bus_clk_in, .rst_n_in,
    .reference_clock_output_out, .refclk_drv_en_out, .addr_out, .ad_oe_out,
    .ale_out, .rd_n_out, .wr_n_out, .cs_n_out);

// ===== test/testbench.sv
/* Self-checking bench for the bus cycle sequencer with a memory partner.
   Assumes the default of two chip selects. */
`timescale 1ns/1ns
`include "ebcs_regs.svh"
module testbench;
    typedef struct packed {logic [4:0] ctrl; logic [12:0] tim; logic cs; logic byt;} ebcs_row_s;
    logic mclk_in = 1'b0;
    logic bus_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out, s;
    logic reference_clock_output_out, refclk_drv_en_out, ad_oe_out, ale_out;
    logic rd_n_out, wr_n_out, high_byte_enable_n_out, ready_in;
    logic [23:0] addr_out;
    logic [15:0] ad_out, ad_in;
    logic [1:0] cs_n_out;
    logic [5:0] wt = 6'h00;
    logic ahi = 1'b1;
    int mismatches = 0, n_tests = 0, n_cs, n_cmd, n_ale, n_bhe, l1, l2, l3;
    ebcs_row_s rows [3] = '{'{5'h11, 13'h0000, 1'b0, 1'b0},
        '{5'h10, 13'h1fff, 1'b1, 1'b1}, '{5'h11, 13'h110c, 1'b0, 1'b1}};

    ebcs_top i_dut (.mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .bus_clk_in, .reference_clock_output_out,
        .refclk_drv_en_out, .addr_out, .ad_out, .ad_oe_out, .ad_in, .ale_out,
        .rd_n_out, .wr_n_out, .high_byte_enable_n_out, .cs_n_out, .ready_in);
    ebcs_mem_model i_mem (.bus_clk_in, .addr_out, .ad_out, .ad_oe_out, .rd_n_out,
        .wr_n_out, .wait_in(wt), .act_hi_in(ahi), .ad_in, .ready_in);

    initial forever #2 mclk_in = ~mclk_in;
    initial begin
        #7;
        forever #80 bus_clk_in = ~bus_clk_in;
    end
    always @(posedge bus_clk_in) begin
        if (!(&cs_n_out)) n_cs++;
        if (!(rd_n_out && wr_n_out)) n_cmd++;
        if (ale_out) n_ale++;
        if (!high_byte_enable_n_out) n_bhe++;
    end

    task automatic complete_run;
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask : rd
    // Poll is bounded so a stuck handshake still ends the run
    task automatic run(input logic [7:0] c, input logic [23:0] a, input logic [15:0] d);
        n_cs = 0;
        n_cmd = 0;
        n_ale = 0;
        n_bhe = 0;
        wr(`EBCS_OFS_ADDR, {8'h00, a});
        wr(`EBCS_OFS_WDATA, {16'h0, d});
        wr(`EBCS_OFS_CMD, {24'h0, c});
        for (int i = 0; i < 2000; i++) begin
            rd(`EBCS_OFS_STATUS, s);
            if (s[1:0] === 2'b10) break;
        end
        chk("status", 32'h2, s);
    endtask : run
    task automatic hs(input logic [4:0] c, input logic [5:0] w, output int l);
        wt = w;
        wr(`EBCS_OFS_CTRL, {27'h0, c});
        run(8'h01, 24'h070005, 16'h0);
        l = n_cmd;
    endtask : hs
    function automatic int cyc(input logic [12:0] t, input logic nw);
        return 2 + t[0] + (nw ? t[2:1] : 2'h0) + t[4:3] + t[5] + t[10:6] + t[12:11];
    endfunction : cyc

    initial begin
        repeat (2) @(posedge bus_clk_in);
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        wr(8'h44, 32'hffffffff);
        rd(`EBCS_OFS_CTRL, s);
        chk("ctrl reset", 32'h11, s);
        rd(`EBCS_OFS_TIM0, s);
        chk("timing reset", 32'h0, s);
        rd(8'h44, s);
        chk("unmapped", 32'h0, s);
        foreach (rows[i]) begin
            wr(`EBCS_OFS_CTRL, {27'h0, rows[i].ctrl});
            wr(8'h04 + {rows[i].cs, 2'b00}, {19'h0, rows[i].tim});
            // Write opens a new window, the read back stays in it
            for (int w = 1; w >= 0; w--) begin
                run({3'h0, rows[i].cs, 1'b0, rows[i].byt, w[0], 1'b1},
                    {i[7:0] + 8'h01, 16'h0005}, {i[3:0], 12'ha5c});
                chk("cs length", cyc(rows[i].tim, w[0]), n_cs);
                chk("cmd length", rows[i].tim[10:6] + 1, n_cmd);
                chk("latch", rows[i].ctrl[0] ? 1 + rows[i].tim[0]
                    + (w[0] ? rows[i].tim[2:1] : 0) : 0, n_ale);
                chk("byte enable", rows[i].byt ? 0 : cyc(rows[i].tim, w[0]), n_bhe);
            end
            rd(`EBCS_OFS_RDATA, s);
            chk("read data", {16'h0, i[3:0], 12'ha5c}, s);
        end
        wr(`EBCS_OFS_TIM0, 32'h0);
        hs(5'h17, 6'h01, l1);
        hs(5'h17, 6'h02, l2);
        chk("one wait per sample", l1 + 1, l2);
        hs(5'h1f, 6'h02, l3);
        chk("async wait", l2 + 1, l3);
        ahi = 1'b0;
        hs(5'h13, 6'h02, l3);
        chk("low polarity", l2, l3);
        ahi = 1'b1;
        wr(`EBCS_OFS_TIM0, 32'h1c0);
        hs(5'h17, 6'h00, l3);
        chk("mandatory waits", 8, l3);
        // Just after a rising edge the gated clock is high only if enabled
        @(posedge bus_clk_in);
        #1;
        chk("refclk on", 32'h3, {30'h0, refclk_drv_en_out, reference_clock_output_out});
        wr(`EBCS_OFS_CTRL, 32'h1);
        repeat (4) @(posedge bus_clk_in);
        #1;
        chk("refclk off", 32'h0, {30'h0, refclk_drv_en_out, reference_clock_output_out});
        complete_run();
    end
    initial begin
        #300000;
        mismatches++;
        complete_run();
    end
endmodule : testbench
